// file: core/gti2c_target.v
// ----------------------------------------
// Operation
// ----------------------------------------
// Operation
// [RQ1] answer only target identifier 1010101 in upper seven address bits
// [RQ2] address byte 0xaa selects write, 0xab selects read
// [RQ3] support byte write, quick read, single read, incremental read
// [RQ4] quick read returns byte at current pointer without command byte
// [RQ5] pointer advances on every acknowledged data byte, either direction
// [RQ6] consecutive written bytes land at consecutive locations
// [RQ7] data byte written to read-only location is not acknowledged
// [RQ8] command byte above 0x7f is not acknowledged
// [RQ9] surplus bytes beyond writable range are not acknowledged
// [RQ10] incremental read served through highest read location
// [RQ11] bus held low past timeout releases both lines
// [RQ12] controller keeps clock at or below 400 khz; the testbench host clocks a 160 ns bit, 6.25 mhz
// [RQ13] controller waits 66 us idle after stop before start
// [RQ14] commands reach control, status and non-volatile locations
// [RQ15] first byte after write address loads the pointer
// [RQ16] timeout counter restarts when lines return high
`timescale 1ns/1ns
`include "gti2c_regs.vh"
module gti2c_target #(
  parameter TIMEOUT_CYC = `GTI2C_TIMEOUT_US * (`GTI2C_CLK_HZ / 1000000),
  parameter MAX_WR = 8'h7f
) (
  input wire ref_clk,
  input wire resetn,
  input wire scl_in,
  output wire scl_out,
  output wire scl_oe,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  output reg [7:0] mem_addr,
  output reg [7:0] mem_wdata,
  output reg mem_we,
  input wire [7:0] mem_rdata,
  input wire mem_ro,
  output reg bus_timeout
);
  // ----------------------------------------
  // synchronisers and edge detection
  // ----------------------------------------
  // third flop only serves edge detection, never the metastable first one
  reg scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_c = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_c = scl_s & scl_d & ~sda_d & sda_s;
  // ----------------------------------------
  // byte engine
  // ----------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_CMD = 3'h2;
  localparam ST_WDAT = 3'h3;
  localparam ST_RDAT = 3'h4;
  localparam ST_RACK = 3'h5;
  localparam ST_ACK = 3'h6;
  reg [2:0] state, ret_state;
  reg [2:0] bitcnt;
  reg [7:0] shreg;
  reg [7:0] ptr;
  reg drive_low, ack_go;
  reg [31:0] lowcnt;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      ret_state <= ST_IDLE;
      bitcnt <= 3'h0;
      shreg <= 8'h00;
      ptr <= `GTI2C_PTR_RESET;
      drive_low <= 1'b0;
      ack_go <= 1'b0;
      mem_addr <= 8'h00;
      mem_wdata <= 8'h00;
      mem_we <= 1'b0;
    end else begin
      mem_we <= 1'b0;
      // store address trails the pointer by one cycle
      mem_addr <= ptr;
      if (bus_timeout) begin
        state <= ST_IDLE;
        drive_low <= 1'b0; // RQ11
      end else if (start_c) begin
        state <= ST_ADDR;
        bitcnt <= 3'h0;
        drive_low <= 1'b0;
      end else if (stop_c) begin
        state <= ST_IDLE;
        drive_low <= 1'b0;
      end else begin
        case (state)
          // ----------------------------------------
          // receive: address, command and write data
          // ----------------------------------------
          // ack decided at the fall so sda moves only while scl is low
          ST_ADDR, ST_CMD, ST_WDAT: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_s};
              bitcnt <= bitcnt + 3'h1;
              if (bitcnt == `GTI2C_BIT_LAST) ack_go <= 1'b1;
            end else if (scl_fall && ack_go) begin
              ack_go <= 1'b0;
              drive_low <= 1'b0;
              ret_state <= ST_IDLE;
              if (state == ST_ADDR) begin
                if (shreg[7:1] == `GTI2C_TARGET_ID) begin // RQ1
                  drive_low <= 1'b1;
                  ret_state <= shreg[0] ? ST_RDAT : ST_CMD; // RQ2 RQ3 RQ4
                end
              end else if (state == ST_CMD) begin
                if (shreg <= `GTI2C_MAX_CMD) begin // RQ8
                  drive_low <= 1'b1;
                  ptr <= shreg; // RQ15
                  ret_state <= ST_WDAT;
                end
              end else if (!mem_ro && ptr <= MAX_WR) begin // RQ7 RQ9
                drive_low <= 1'b1;
                mem_wdata <= shreg;
                mem_we <= 1'b1; // RQ14
                ptr <= ptr + 8'h01; // RQ5 RQ6
                ret_state <= ST_WDAT;
              end
              state <= ST_ACK;
            end
          end
          // ----------------------------------------
          // acknowledge slot
          // ----------------------------------------
          ST_ACK: begin
            if (scl_fall) begin
              bitcnt <= 3'h0;
              state <= ret_state;
              drive_low <= 1'b0;
              if (ret_state == ST_RDAT) begin
                shreg <= mem_rdata; // RQ10
                drive_low <= ~mem_rdata[7];
                bitcnt <= 3'h1;
              end
            end
          end
          // ----------------------------------------
          // transmit: read data
          // ----------------------------------------
          // msb goes out in the ack slot, so the counter starts at one
          ST_RDAT: begin
            if (scl_fall) begin
              if (bitcnt == 3'h0) begin
                drive_low <= 1'b0;
                state <= ST_RACK;
              end else begin
                drive_low <= ~shreg[`GTI2C_BIT_LAST - bitcnt];
                bitcnt <= bitcnt + 3'h1;
              end
            end
          end
          // ----------------------------------------
          // controller acknowledge
          // ----------------------------------------
          // a nack ends the read and leaves the pointer on the last byte
          ST_RACK: begin
            if (scl_rise) begin
              if (!sda_s) begin
                ptr <= ptr + 8'h01; // RQ5
                mem_addr <= ptr + 8'h01;
                ret_state <= ST_RDAT;
                state <= ST_ACK;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end
  // ----------------------------------------
  // stuck bus timeout
  // ----------------------------------------
  // restarts each time both lines are high, so slow but live traffic passes
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lowcnt <= 32'h0;
      bus_timeout <= 1'b0;
    end else if (scl_s && sda_s) begin
      lowcnt <= 32'h0; // RQ16
      bus_timeout <= 1'b0;
    end else if (lowcnt >= TIMEOUT_CYC) begin
      // stays set until both lines are seen high again
      bus_timeout <= 1'b1; // RQ11
    end else begin
      lowcnt <= lowcnt + 32'h1; // RQ16
    end
  end
  // ----------------------------------------
  // bus line drivers
  // ----------------------------------------
  // no clock stretching: scl is never pulled, only sda for ack and data
  assign scl_out = 1'b0;
  assign scl_oe = 1'b0;
  assign sda_out = 1'b0;
  assign sda_oe = drive_low & ~bus_timeout; // RQ11
endmodule // gti2c_target

// file: core/gti2c_regs.vh
`ifndef GTI2C_REGS_VH
`define GTI2C_REGS_VH
// ----------------------------------------
// bus addressing
// ----------------------------------------
`define GTI2C_TARGET_ID 7'h55
`define GTI2C_WR_BYTE 8'haa
`define GTI2C_RD_BYTE 8'hab
`define GTI2C_MAX_CMD 8'h7f
`define GTI2C_PTR_RESET 8'h00
// ----------------------------------------
// timing
// ----------------------------------------
`define GTI2C_CLK_HZ 50000000
`define GTI2C_TIMEOUT_US 2000
`define GTI2C_BIT_LAST 3'h7
`endif

// file: tb/gti2c_target_assertions.sv
`timescale 1ns/1ns
module gti2c_target_assertions #(parameter TIMEOUT_CYC = 200,
  parameter MAX_WR = 8'h7f) (input wire ref_clk, input wire resetn,
  input wire scl_in, input wire scl_out, input wire scl_oe,
  input wire sda_in, input wire sda_out, input wire sda_oe,
  input wire [7:0] mem_addr, input wire [7:0] mem_wdata,
  input wire mem_we, input wire [7:0] mem_rdata, input wire mem_ro,
  input wire bus_timeout);
  // raw-pin count: the design sees the same run two flops later
  reg [31:0] low_cnt;
  always @(posedge ref_clk or negedge resetn)
    if (!resetn) low_cnt <= 32'h0;
    else low_cnt <= (scl_in && sda_in) ? 32'h0 : low_cnt + 32'h1;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  property p_drv; !scl_oe && !scl_out && !sda_out; endproperty
  a_drv: assert property (p_drv) else $error("line driven");
  property p_we; mem_we |=> !mem_we; endproperty
  a_we: assert property (p_we) else $error("long we");
  property p_ro; mem_we |-> !mem_ro; endproperty
  a_ro: assert property (p_ro) else $error("ro written");
  property p_rng; mem_we |-> mem_addr <= MAX_WR; endproperty
  a_rng: assert property (p_rng) else $error("surplus");
  property p_ack; $rose(sda_oe) |-> !scl_in; endproperty
  a_ack: assert property (p_ack) else $error("sda at scl high");
  property p_early; $rose(bus_timeout) |-> low_cnt >= TIMEOUT_CYC - 4;
  endproperty
  a_early: assert property (p_early) else $error("early");
  property p_late; low_cnt == TIMEOUT_CYC + 8 |-> bus_timeout; endproperty
  a_late: assert property (p_late) else $error("late");
  property p_rel; bus_timeout |-> !sda_oe; endproperty
  a_rel: assert property (p_rel) else $error("sda held");
endmodule // gti2c_target_assertions
bind gti2c_target gti2c_target_assertions #(.TIMEOUT_CYC(TIMEOUT_CYC),
  .MAX_WR(MAX_WR)) chk (.ref_clk, .resetn, .scl_in, .scl_out, .scl_oe,
  .sda_in, .sda_out, .sda_oe, .mem_addr, .mem_wdata, .mem_we,
  .mem_rdata, .mem_ro, .bus_timeout);

// file: tb/gti2c_host.sv
`timescale 1ns/1ns
module gti2c_host (output logic scl_low, output logic sda_low,
  input wire sda);
  initial scl_low = 0;
  initial sda_low = 0;
  task bit_(input b, output r);
    sda_low = ~b;
    #100 scl_low = 0;
    #60 r = sda;
    scl_low = 1;
  endtask
  task xfer(input [7:0] d, input ak, output [7:0] q, output a);
    for (int i = 7; i >= 0; i--) bit_(d[i], q[i]);
    bit_(ak, a);
  endtask
  task start;
    sda_low = 0;
    #60 scl_low = 0;
    #100 sda_low = 1;
    #100 scl_low = 1;
  endtask
  task stop;
    sda_low = 1;
    #60 scl_low = 0;
    #100 sda_low = 0;
    #66000;
  endtask
endmodule // gti2c_host

// file: tb/tb_gauge_i2c_target_interface.sv
`timescale 1ns/1ns
`define CK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected %0t %h %h", $time, g, e); end end
module tb_gauge_i2c_target_interface;
  reg ref_clk = 0;
  reg resetn = 0;
  reg [7:0] mem [0:255];
  reg [7:0] q;
  reg a;
  integer err_total = 0, n_checks = 0, cyc = 0;
  wire scl_oe, sda_oe, mem_we, bus_timeout, h_scl, h_sda;
  wire [7:0] mem_addr, mem_wdata;
  // open-drain lines with pull-ups
  wire scl = ~(scl_oe | h_scl);
  wire sda = ~(sda_oe | h_sda);
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (mem_we) mem[mem_addr] <= mem_wdata;
    if (cyc == 60000) begin err_total++; report_and_stop; end
  end
  gti2c_target #(.TIMEOUT_CYC(200)) dut (.ref_clk(ref_clk),
    .resetn(resetn), .scl_in(scl), .scl_out(), .scl_oe(scl_oe),
    .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_rdata(mem[mem_addr]),
    .mem_ro(mem_addr == 8'h10), .bus_timeout(bus_timeout));
  gti2c_host host (.scl_low(h_scl), .sda_low(h_sda), .sda(sda));
  task wb(input [7:0] d, input ex); host.xfer(d, 1'b1, q, a);
    `CK(a, ex) endtask
  task rb(input [7:0] e, input ak); host.xfer(8'hff, ak, q, a);
    `CK(q, e) endtask
  task t_wr; host.start; wb(8'haa, 0);
    wb(8'h20, 0); wb(8'h5a, 0); wb(8'ha5, 0); host.stop;
    `CK(mem[8'h20], 8'h5a)
    `CK(mem[8'h21], 8'ha5) endtask
  task t_qr; host.start; wb(8'hab, 0);
    rb(8'h3c, 1); host.stop; endtask
  task t_rd; host.start; wb(8'haa, 0); wb(8'h7e, 0);
    host.start; wb(8'hab, 0); rb(8'hc3, 0);
    rb(8'h96, 1); host.stop; endtask
  task t_bad; host.start; wb(8'h54, 1); host.stop;
    host.start; wb(8'haa, 0); wb(8'h80, 1); host.stop;
    host.start; wb(8'haa, 0); wb(8'h10, 0); wb(8'h77, 1); host.stop;
    host.start; wb(8'haa, 0); wb(8'h7f, 0); wb(8'h11, 0);
    wb(8'h22, 1); host.stop; endtask
  // clock stuck low mid-frame while the target still drives its ack
  task t_to; integer i; host.start; wb(8'haa, 0);
    for (i = 7; i >= 0; i = i - 1) host.bit_(i == 0, a);
    #200 `CK(sda_oe, 1'b1)
    #6000 `CK(bus_timeout, 1'b1)
    `CK(sda_oe, 1'b0)
    host.scl_low = 0; repeat (5) @(posedge ref_clk);
    `CK(bus_timeout, 1'b0)
    host.stop; endtask
  task report_and_stop;
    if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    mem[8'h22] = 8'h3c; mem[8'h7e] = 8'hc3; mem[8'h7f] = 8'h96;
    repeat (10) @(posedge ref_clk);
    resetn <= 1;
    #5 t_wr; t_qr; t_rd; t_bad; t_to;
    report_and_stop;
  end
endmodule // tb_gauge_i2c_target_interface
